// ---- pcg_defs.vh ----
// Constants for the PLL clock generator block
`ifndef PCG_DEFS_VH
`define PCG_DEFS_VH
// APB register offsets (byte addresses)
`define PCG_CTRL_OFS      8'h00
`define PCG_STATUS_OFS    8'h04
`define PCG_PERIOD_OFS    8'h08
// Control register fields and reset value
`define PCG_CTRL_HALVE    0
`define PCG_CTRL_WAKE_INT 1
`define PCG_CTRL_RST      2'h3
// Status register field positions
`define PCG_ST_MODE       0
`define PCG_ST_PWR        2
`define PCG_ST_LOCK       3
`define PCG_ST_STABLE     4
`define PCG_ST_DIV        5
`define PCG_ST_WAKE       7
`define PCG_ST_LCNT       8
// Divider settings on the select input
`define PCG_DIV_FULL      2'h0
`define PCG_DIV_SIXTEENTH 2'h1
`define PCG_DIV_STOP      2'h2
// Clock_a codes shown on the clock_a output
`define PCG_CLOCK_A_ONE     2'h0
`define PCG_CLOCK_A_HALF    2'h1
`define PCG_CLOCK_A_FIVE    2'h2
// Timing counts
`define PCG_MULT          3'h5
`define PCG_SLOW_DIV      4'hf
`define PCG_LOCK_LAST     8'hff
`endif

// ---- pcg_clock_gen.v ----
// PLL clock generator: source merge, mode decode, x5 multiplier, divider, phase clocks
//
// How it works
// - PLL mode core clock is five times reference
// - Crystal and external inputs merged by XOR
// - Two select pins decode into four modes
// - 00 static, 01 half, 10 full, bypassed
// - 11 enables feedback, PLL power, x5
// - PLL acquires lock, then keeps tracking
// - Fixed x5 multiplier, bypassable, power controlled
// - Divider gives full, sixteenth or stopped clock
// - Reset or low interrupt pin wakes stopped clock
// - Compat mode halves, phase set at reset fall
// - Half reference for 256 cycles, then x5
// - Lock counter holds in reset, stays cleared
//
// Chosen here: the placing of the registers and register access over APB.
`include "pcg_defs.vh"
module pcg_clock_gen #(
   parameter PW = 16,
   parameter NI = 4
)(
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   input  wire          crystal_input,
   input  wire          external_reference_input,
   input  wire          clock_mode_select_low,
   input  wire          clock_mode_select_high,
   input  wire          device_reset_n,
   input  wire [NI-1:0] int_n,
   input  wire [1:0]    div_select,
   output reg           div_ack,
   output reg           crystal_drive_output,
   output reg           pll_power_enable,
   output reg  [1:0]    clock_a,
   output reg           core_clk_en,
   output reg           phase_clock_one,
   output reg           phase_clock_three
);

   // Two-flop synchronisers for every pin input
   reg  [1:0]    xin_s_q;
   reg  [1:0]    ext_s_q;
   reg  [1:0]    md0_s_q;
   reg  [1:0]    md1_s_q;
   reg  [1:0]    rst_s_q;
   reg  [NI-1:0] int_a_q;
   reg  [NI-1:0] int_b_q;
   reg  [1:0]    sel_a_q;
   reg  [1:0]    sel_b_q;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         xin_s_q <= 2'h0;
         ext_s_q <= 2'h0;
         md0_s_q <= 2'h0;
         md1_s_q <= 2'h0;
         rst_s_q <= 2'h0;
         int_a_q <= {NI{1'b1}};
         int_b_q <= {NI{1'b1}};
         sel_a_q <= 2'h0;
         sel_b_q <= 2'h0;
      end
      else
      begin
         xin_s_q <= {xin_s_q[0], crystal_input};
         ext_s_q <= {ext_s_q[0], external_reference_input};
         md0_s_q <= {md0_s_q[0], clock_mode_select_low};
         md1_s_q <= {md1_s_q[0], clock_mode_select_high};
         rst_s_q <= {rst_s_q[0], device_reset_n};
         int_a_q <= int_n;
         int_b_q <= int_a_q;
         sel_a_q <= div_select;
         sel_b_q <= sel_a_q;
      end
   end

   // Unused input is grounded, so XOR passes the live source
   wire       ref_lvl = xin_s_q[1] ^ ext_s_q[1];
   wire [1:0] mode    = {md0_s_q[1], md1_s_q[1]};
   wire       rst_ok  = rst_s_q[1];
   wire       pll_on  = (mode == 2'h3);
   reg        ref_d_q;
   reg        rst_d_q;
   wire       ref_edge = ref_lvl & ~ref_d_q;
   wire       rst_fall = rst_d_q & ~rst_ok;

   // Mode decode into feedback, PLL power and clock_a
   reg [1:0] clock_a_d;
   always @*
   begin
      case (mode)
         2'h0:    clock_a_d = `PCG_CLOCK_A_ONE;
         2'h1:    clock_a_d = `PCG_CLOCK_A_HALF;
         2'h2:    clock_a_d = `PCG_CLOCK_A_ONE;
         2'h3:    clock_a_d = `PCG_CLOCK_A_FIVE;
         default: clock_a_d = `PCG_CLOCK_A_ONE;
      endcase
   end

   // Reference period meter; lock when two periods agree within one cycle
   reg  [PW-1:0] cnt_q;
   reg  [PW-1:0] per_q;
   reg           locked_q;
   wire [PW-1:0] diff = (cnt_q > per_q) ? cnt_q - per_q : per_q - cnt_q;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_d_q  <= 1'b0;
         rst_d_q  <= 1'b0;
         cnt_q    <= {PW{1'b0}};
         per_q    <= {PW{1'b0}};
         locked_q <= 1'b0;
      end
      else
      begin
         ref_d_q <= ref_lvl;
         rst_d_q <= rst_ok;
         if (!pll_on)
         begin
            cnt_q    <= {PW{1'b0}};
            locked_q <= 1'b0;
         end
         else if (ref_edge)
         begin
            cnt_q    <= {{(PW-1){1'b0}}, 1'b1}; // Edge cycle counts as one
            per_q    <= cnt_q;
            locked_q <= (diff <= {{(PW-1){1'b0}}, 1'b1});
         end
         else if (cnt_q != {PW{1'b1}})
            cnt_q <= cnt_q + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   // Lock counter only advances on reference edges out of reset
   reg [7:0] lcnt_q;
   reg       stable_q;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lcnt_q   <= 8'h00;
         stable_q <= 1'b0;
      end
      else if (pll_on && rst_ok && ref_edge && !stable_q)
      begin
         if (lcnt_q == `PCG_LOCK_LAST)
         begin
            lcnt_q   <= 8'h00;
            stable_q <= 1'b1;
         end
         else
            lcnt_q <= lcnt_q + 8'h01;
      end
   end

   // Five evenly spaced ticks per reference period, realigned each edge
   wire [PW-1:0] slot = per_q / `PCG_MULT;
   reg  [PW-1:0] slot_q;
   reg  [2:0]    nt_q;
   reg           half_q;
   wire          x5_run = locked_q & stable_q;
   reg           btick;
   always @*
   begin
      btick = 1'b0;
      case (clock_a_d)
         `PCG_CLOCK_A_ONE:  btick = ref_edge;
         `PCG_CLOCK_A_HALF: btick = ref_edge & half_q;
         `PCG_CLOCK_A_FIVE:
            if (!x5_run)
               btick = ref_edge & half_q & rst_ok;
            else
               btick = ref_edge |
                       ((slot_q == slot) && (nt_q < `PCG_MULT));
         default:         btick = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_q <= {PW{1'b0}};
         nt_q   <= 3'h0;
         half_q <= 1'b0;
      end
      else
      begin
         if (ref_edge)
            half_q <= ~half_q;
         // Switching at a reference edge keeps the x5 change glitch free
         if (ref_edge)
         begin
            slot_q <= {{(PW-1){1'b0}}, 1'b1};
            nt_q   <= 3'h1;
         end
         else if (slot_q == slot)
         begin
            slot_q <= {{(PW-1){1'b0}}, 1'b1};
            if (nt_q < `PCG_MULT)
               nt_q <= nt_q + 3'h1;
         end
         else
            slot_q <= slot_q + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   // Divider; new select setting is taken only at a base tick with count empty, a wake from stop at once
   reg [1:0] div_q;
   reg [3:0] dcnt_q;
   reg       wake_q;
   reg [1:0] ctrl_q;
   wire      wake_src = ~rst_ok |
                        (ctrl_q[`PCG_CTRL_WAKE_INT] & ~(&int_b_q));
   wire      at_bound = btick & (dcnt_q == 4'h0);
   wire [1:0] want    = wake_q ? `PCG_DIV_FULL : sel_b_q;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_q   <= `PCG_DIV_FULL;
         dcnt_q  <= 4'h0;
         wake_q  <= 1'b0;
         div_ack <= 1'b1;
      end
      else
      begin
         // A stopped clock has no ticks, so wake overrides at once
         if (div_q == `PCG_DIV_STOP && wake_src)
         begin
            div_q  <= `PCG_DIV_FULL;
            wake_q <= 1'b1;
            dcnt_q <= 4'h0;
         end
         else
         begin
            if (sel_b_q != `PCG_DIV_STOP)
               wake_q <= 1'b0;
            if (at_bound && want != div_q)
               div_q <= want;
            if (btick && div_q == `PCG_DIV_SIXTEENTH)
               dcnt_q <= dcnt_q + 4'h1;
            else if (btick)
               dcnt_q <= 4'h0;
         end
         div_ack <= (div_q == want);
      end
   end

   reg dtick;
   always @*
   begin
      case (div_q)
         `PCG_DIV_FULL:      dtick = btick;
         `PCG_DIV_SIXTEENTH: dtick = btick & (dcnt_q == `PCG_SLOW_DIV);
         `PCG_DIV_STOP:      dtick = 1'b0;
         default:            dtick = 1'b0;
      endcase
   end

   // Compatibility halving; its phase is caught from H1 at reset fall
   reg  hv_q;
   wire halve = ctrl_q[`PCG_CTRL_HALVE];
   wire ctick = dtick & (~halve | hv_q);
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hv_q                 <= 1'b0;
         core_clk_en          <= 1'b0;
         phase_clock_one      <= 1'b0;
         phase_clock_three    <= 1'b1;
         crystal_drive_output <= 1'b0;
         pll_power_enable     <= 1'b0;
         clock_a              <= `PCG_CLOCK_A_ONE;
      end
      else
      begin
         if (rst_fall)
            hv_q <= phase_clock_one;
         else if (dtick)
            hv_q <= ~hv_q;
         core_clk_en <= ctick;
         if (ctick)
         begin
            phase_clock_one   <= ~phase_clock_one;
            phase_clock_three <= phase_clock_one;
         end
         // Feedback drives the inverse of the crystal input
         crystal_drive_output <= (mode != 2'h0) & ~xin_s_q[1];
         pll_power_enable     <= pll_on;
         clock_a              <= clock_a_d;
      end
   end

   // APB slave: zero wait states, error on unmapped offsets
   wire       setup = psel & ~penable;
   wire       hit   = (paddr == `PCG_CTRL_OFS) | (paddr == `PCG_STATUS_OFS) |
                      (paddr == `PCG_PERIOD_OFS);
   reg [31:0] rd_d;
   always @*
   begin
      rd_d = 32'h0;
      case (paddr)
         `PCG_CTRL_OFS:   rd_d = {30'h0, ctrl_q};
         `PCG_STATUS_OFS: rd_d = {16'h0, lcnt_q, wake_q, div_q, stable_q,
                                  locked_q, pll_on, mode};
         `PCG_PERIOD_OFS: rd_d = {{(32-PW){1'b0}}, per_q};
         default:         rd_d = 32'h0;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q  <= `PCG_CTRL_RST;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         if (setup && !pwrite)
            prdata <= rd_d;
         // Write lands at the access edge, when pready is high
         if (psel && penable && pready && pwrite && paddr == `PCG_CTRL_OFS)
            ctrl_q <= pwdata[1:0];
      end
   end

endmodule

// ---- pcg_ref_src.sv ----
// Reference clock source model standing in for crystal or external clock
module pcg_ref_src #(
   parameter int HALF = 10
)(
   input  wire logic pclk,
   output logic      ref_clk = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt_q = 0;
   // Free-running square wave, a real oscillator never pauses
   always @(posedge pclk)
   begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1)
         ref_clk <= ~ref_clk;
   end
endmodule

// ---- pcg_clock_gen_properties.sv ----
// Port checker for the PLL clock generator
`include "pcg_defs.vh"
module pcg_clock_gen_properties #(
   parameter NI = 4
)(
   input wire          pclk,
   input wire          presetn,
   input wire          crystal_input,
   input wire          clock_mode_select_low,
   input wire          clock_mode_select_high,
   input wire          device_reset_n,
   input wire [NI-1:0] int_n,
   input wire [1:0]    div_select,
   input wire          div_ack,
   input wire          crystal_drive_output,
   input wire          pll_power_enable,
   input wire [1:0]    clock_a,
   input wire          core_clk_en,
   input wire          phase_clock_one,
   input wire          phase_clock_three
);
   wire [1:0] m = {clock_mode_select_low, clock_mode_select_high};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Six stable cycles cover the pin synchroniser delay
   AST_MODE00: assert property ((m == 2'h0 && !crystal_input)[*6] |->
      !pll_power_enable && !crystal_drive_output) else $error("mode 0 outputs wrong");
   AST_MODE01: assert property ((m == 2'h1)[*6] |->
      clock_a == `PCG_CLOCK_A_HALF && !pll_power_enable) else $error("mode 1 outputs wrong");
   AST_MODE10: assert property ((m == 2'h2 && !crystal_input)[*6] |->
      clock_a == `PCG_CLOCK_A_ONE && crystal_drive_output) else $error("mode 2 outputs wrong");
   AST_MODE11: assert property ((m == 2'h3)[*6] |->
      pll_power_enable && clock_a == `PCG_CLOCK_A_FIVE) else $error("mode 3 outputs wrong");
   AST_TICK: assert property (core_clk_en |=> !core_clk_en)
      else $error("tick pulse too long");
   AST_PHASE: assert property (phase_clock_three != phase_clock_one)
      else $error("phase clocks overlap");
   AST_TOGGLE: assert property (core_clk_en |-> phase_clock_one != $past(phase_clock_one))
      else $error("phase clock missed a tick");
   AST_STOP: assert property ((div_ack && div_select == `PCG_DIV_STOP &&
      device_reset_n && &int_n)[*8] |-> !core_clk_en) else $error("tick while stopped");
endmodule
bind pcg_clock_gen pcg_clock_gen_properties #(.NI(NI)) pcg_props_inst (.*);

// ---- pll_clock_generator_bench.sv ----
// Self-checking bench for the PLL clock generator
`include "pcg_defs.vh"
module pll_clock_generator_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int P = 20; // Reference period in pclk cycles
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, xsel = 0, ref_clk;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, div_ack, crystal_drive_output, pll_power_enable;
   logic clock_mode_select_low = 1, clock_mode_select_high = 0, device_reset_n = 1;
   logic [3:0] int_n = 4'hf;
   logic [1:0] div_select = `PCG_DIV_FULL, clock_a;
   logic core_clk_en, phase_clock_one, phase_clock_three;
   int errors = 0, checks = 0;
   // Unused reference input held low so the merge passes the other
   wire crystal_input = xsel & ref_clk;
   wire external_reference_input = ~xsel & ref_clk;
   pcg_clock_gen pcg_clock_gen_inst (.*);
   pcg_ref_src pcg_ref_src_inst (.pclk(pclk), .ref_clk(ref_clk));
   always #2.5 pclk = ~pclk;
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("MISMATCH %0t ticks %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // APB cycle; holds the request until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
      if (n >= 50)
      begin
         errors++;
         stop_test();
      end
   endtask
   task automatic idle(input int per);
      repeat (per * P) @(posedge pclk);
   endtask
   // Counts core ticks over a number of reference periods
   task automatic ticks(input int per, input int lo, input int hi);
      int n;
      n = 0;
      repeat (per * P)
      begin
         @(posedge pclk);
         if (core_clk_en === 1'b1)
            n++;
      end
      chk_rng(n, lo, hi);
   endtask
   // Divider change lands only at a base tick with the sixteenth count empty, so allow long waits
   task automatic sel_div(input logic [1:0] s);
      int n;
      div_select <= s;
      repeat (4) @(posedge pclk);
      n = 0;
      while (div_ack !== 1'b1 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      chk(div_ack, 1'b1);
      if (n >= 2000)
         stop_test();
   endtask
   task automatic test_regs;
      apb(0, `PCG_CTRL_OFS, 0);
      chk(rd, `PCG_CTRL_RST);
      apb(1, `PCG_CTRL_OFS, 32'h2);
      apb(0, `PCG_CTRL_OFS, 0);
      chk(rd, 32'h2);
      apb(1, `PCG_STATUS_OFS, 32'hffffffff);
      chk(er, 0);
      apb(0, `PCG_STATUS_OFS, 0);
      chk(rd[1:0], 2'h2);
      apb(0, 8'h0c, 0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test_regs done");
   endtask
   task automatic test_modes;
      idle(10);
      ticks(40, 39, 41);
      xsel <= 1;
      idle(5);
      ticks(40, 39, 41);
      xsel <= 0;
      clock_mode_select_low <= 0;
      clock_mode_select_high <= 1;
      idle(5);
      ticks(40, 19, 21);
      clock_mode_select_high <= 0;
      idle(2);
      {clock_mode_select_low, clock_mode_select_high} <= 2'h3;
      idle(5);
      ticks(20, 9, 11);
      idle(300);
      ticks(20, 99, 101);
      apb(0, `PCG_STATUS_OFS, 0);
      chk({rd[15:8], rd[4:2]}, {8'h00, 3'h7});
      apb(0, `PCG_PERIOD_OFS, 0);
      chk(rd, P);
      device_reset_n <= 0;
      idle(5);
      device_reset_n <= 1;
      idle(3);
      ticks(20, 99, 101);
      {clock_mode_select_low, clock_mode_select_high} <= 2'h2;
      $display("test_modes done");
   endtask
   task automatic test_div;
      idle(5);
      sel_div(`PCG_DIV_SIXTEENTH);
      ticks(64, 3, 5);
      sel_div(`PCG_DIV_STOP);
      ticks(20, 0, 0);
      int_n <= 4'he;
      idle(3);
      ticks(20, 19, 21);
      sel_div(`PCG_DIV_FULL);
      int_n <= 4'hf;
      sel_div(`PCG_DIV_STOP);
      ticks(10, 0, 0);
      device_reset_n <= 0;
      idle(3);
      ticks(10, 9, 11);
      sel_div(`PCG_DIV_FULL);
      device_reset_n <= 1;
      $display("test_div done");
   endtask
   task automatic test_halve;
      apb(1, `PCG_CTRL_OFS, 32'h3);
      idle(5);
      ticks(40, 19, 21);
      $display("test_halve done");
   endtask
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      test_regs();
      test_modes();
      test_div();
      test_halve();
      stop_test();
   end
endmodule
